// ==== core/caw_watchdog.sv ====
// Purpose: activity supervisor with sanity timer, mate watch and takeover
// Assumes: all inputs synchronous to core_clk; commands are one-cycle pulses
// Notes:   drop pulse is one cycle per switch-over
`timescale 1ns/1ps
// Summary of operation
// - a sanity timer of 200 ms expires unless the processor restarts it in time.
// - while the timer runs the activity line shows sane.
// - on expiry the activity line shows inoperative.
// - only a full ordered key sequence restarts the timer.
// - the mate activity line is watched and an inoperative mate raises a failure flag.
// - takeover deselects the primary bus interface and selects the secondary one.
// - in takeover one ring interface drives the failed bay generator, the other our own.
// - the ring interface handed over is picked at random when takeover begins.
// - every switch-over and switch back releases all calls.
// - a repaired bay restarts its timer by key sequence and its sane line is seen by the mate.
// - a sane mate alone never switches back; only return to service does.
module caw_watchdog
  import caw_pkg::*;
#(
  parameter int unsigned SANITY_CYCLES = SANITY_CYC
) (
  input  wire logic             core_clk,              // system clock
  input  wire logic             reset_n,               // async reset, active low
  input  wire logic             key_wr,                // processor key strobe
  input  wire logic [KEY_W-1:0] key_data,              // processor key value
  input  wire logic             mate_activity_sane,    // mate activity line, high = sane
  input  wire logic             takeover_cmd,          // takeover command pulse
  input  wire logic             return_to_service_cmd, // switch back command pulse
  input  wire logic             failure_ack,           // clears failure flag
  output logic                  activity_sane,         // our activity line, high = sane
  output logic                  mate_failed,           // failure notice to host control
  output logic                  mate_recovered,        // mate sane while in takeover
  output logic                  takeover_active,       // takeover in effect
  output logic                  primary_bi_en,         // mate drawer primary interface enable
  output logic                  secondary_bi_en,       // mate drawer secondary interface enable
  output logic                  ring_if_sel,           // ring interface serving failed bay
  output logic                  call_drop              // release all calls, one cycle
);
  localparam int unsigned CW = $clog2(SANITY_CYCLES + 1);
  // refuse a period too short for the countdown to reload and expire
  if (SANITY_CYCLES < 2) begin : g_bad_period
    $error("caw_watchdog: SANITY_CYCLES too small");
  end

  logic          kick;
  logic [CW-1:0] tmr_q;
  logic          sane_q;
  logic          fail_q;
  logic          tko_q;
  logic          sel_q;
  logic          drop_q;
  logic [15:0]   lfsr_q;

  caw_lock u_lock (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .key_wr   (key_wr),
    .key_data (key_data),
    .kick     (kick)
  );

  // sanity timer counts down, reloads on kick
  // sanity period countdown
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)          tmr_q <= CW'(SANITY_CYCLES - 1);
    else if (kick)         tmr_q <= CW'(SANITY_CYCLES - 1);
    else if (tmr_q != '0)  tmr_q <= tmr_q - 1'b1;
  end

  // activity line level
  // sane while running
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)           sane_q <= 1'b1;
    else if (kick)          sane_q <= 1'b1;
    else if (tmr_q == '0)   sane_q <= 1'b0;
  end
  assign activity_sane = sane_q;

  // failure flag, set wins over acknowledge
  // mate failure notice
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)                 fail_q <= 1'b0;
    else if (!mate_activity_sane) fail_q <= 1'b1;
    else if (failure_ack)         fail_q <= 1'b0;
  end
  assign mate_failed    = fail_q;
  assign mate_recovered = tko_q & mate_activity_sane;

  // free-running random source
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) lfsr_q <= LFSR_SEED;
    else          lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end

  // takeover state and switch back
  // interface switch-over
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)                              tko_q <= 1'b0;
    else if (!tko_q && takeover_cmd)           tko_q <= 1'b1;
    else if (tko_q && return_to_service_cmd)   tko_q <= 1'b0;
  end

  // ring interface pick at takeover start
  // random pick
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)                    sel_q <= 1'b0;
    else if (!tko_q && takeover_cmd) sel_q <= lfsr_q[0];
  end

  // call release on each switch
  // drop calls on switch
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) drop_q <= 1'b0;
    else drop_q <= (!tko_q && takeover_cmd) || (tko_q && return_to_service_cmd);
  end

  assign takeover_active = tko_q;
  assign primary_bi_en   = ~tko_q;
  assign secondary_bi_en = tko_q;
  assign ring_if_sel     = sel_q;
  assign call_drop       = drop_q;

  // check helper: cycles since the last restart, kept apart from the countdown
  // so that a wrong reload value in the timer cannot hide from the checks
  logic [CW-1:0] since_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)                           since_q <= '0;
    else if (kick)                          since_q <= '0;
    else if (since_q != CW'(SANITY_CYCLES)) since_q <= since_q + 1'b1;
  end

  // steps of a switch-over, a switch back and the one-cycle call release
  sequence s_tko_start;
    !tko_q && takeover_cmd;
  endsequence
  sequence s_rts_taken;
    tko_q && return_to_service_cmd;
  endsequence
  sequence s_drop_once;
    call_drop ##1 !call_drop;
  endsequence

  chk_expiry_inop: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (tmr_q == '0 && !kick) |=> !activity_sane)
    else $error("no inoperative after expiry");
  chk_kick_sane: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    kick |=> activity_sane && tmr_q == CW'(SANITY_CYCLES - 1))
    else $error("kick did not reload");
  chk_running_sane: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (activity_sane && tmr_q != '0) |=> activity_sane)
    else $error("sane dropped early");
  chk_timer_counts: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!kick && tmr_q != '0) |=> tmr_q == $past(tmr_q) - 1'b1)
    else $error("timer not counting");
  chk_full_period: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (since_q < CW'(SANITY_CYCLES)) |-> activity_sane)
    else $error("sane lost inside the period");
  // inoperative once the period is over
  chk_expired_inop: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (since_q == CW'(SANITY_CYCLES)) |-> !activity_sane)
    else $error("sane kept past the period");
  chk_inop_holds: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!activity_sane && !kick) |=> !activity_sane)
    else $error("sane back without restart");
  chk_mate_fail: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !mate_activity_sane |=> mate_failed)
    else $error("mate failure missed");
  chk_fail_sticky: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mate_failed && !failure_ack) |=> mate_failed)
    else $error("failure notice lost");
  chk_ack_clears: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mate_failed && failure_ack && mate_activity_sane) |=> !mate_failed)
    else $error("acknowledge did not clear");
  chk_switch_over: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_tko_start |=> secondary_bi_en && !primary_bi_en && call_drop)
    else $error("takeover switch wrong");
  chk_back_restores: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_rts_taken |=> primary_bi_en && !secondary_bi_en)
    else $error("switch back interfaces wrong");
  chk_no_auto_back: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (tko_q && !return_to_service_cmd) |=> tko_q)
    else $error("switch back without command");
  chk_back_drops: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_rts_taken ##1 !takeover_cmd |-> s_drop_once)
    else $error("switch back without drop");
  // calls released only on a switch
  chk_drop_cause: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    call_drop |-> ($past(takeover_cmd) && !$past(tko_q)) ||
                  ($past(return_to_service_cmd) && $past(tko_q)))
    else $error("calls released without switch");
  // pick taken from the random source
  chk_sel_latched: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    s_tko_start |=> ring_if_sel == $past(lfsr_q[0]))
    else $error("ring pick not from random source");
  chk_sel_stable: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (tko_q && !return_to_service_cmd) |=> $stable(ring_if_sel))
    else $error("ring pick changed in takeover");
endmodule : caw_watchdog

// ==== core/caw_pkg.sv ====
// Purpose: shared constants for the controller activity watchdog
// Assumes: one 200 MHz clock
// Notes:   lock key values are arbitrary
package caw_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SANITY_MS        = 200;
  localparam int unsigned SANITY_CYC       = SANITY_MS * 1000 * CLK_MHZ;
  localparam int unsigned KEY_W            = 8;
  localparam logic [7:0]  KEY_FIRST        = 8'h5a; // arbitrary key value
  localparam logic [7:0]  KEY_SECOND       = 8'ha5; // arbitrary key value
  localparam logic [7:0]  KEY_THIRD        = 8'hc3; // arbitrary key value
  localparam int unsigned LOCK_TIMEOUT_CYC = 256;
  localparam logic [15:0] LFSR_SEED        = 16'hace1; // arbitrary nonzero seed

  typedef enum logic [3:0] {
    CAW_LK_IDLE  = 4'b0001,
    CAW_LK_ONE   = 4'b0010,
    CAW_LK_TWO   = 4'b0100,
    CAW_LK_KICK  = 4'b1000
  } caw_lock_t;
endpackage : caw_pkg

// ==== core/caw_lock.sv ====
// Purpose: ordered key sequence that unlocks one timer restart
// Assumes: key writes are single-cycle strobes
// Notes:   an idle gap or a wrong key returns to the locked state
`timescale 1ns/1ps
module caw_lock
  import caw_pkg::*;
#(
  parameter int unsigned GAP_CYC = LOCK_TIMEOUT_CYC
) (
  input  wire logic             core_clk,  // system clock
  input  wire logic             reset_n,   // async reset, active low
  input  wire logic             key_wr,    // key write strobe
  input  wire logic [KEY_W-1:0] key_data,  // key value
  output logic                  kick       // one-cycle valid restart
);
  // refuse a gap too short to tell a pause from back-to-back keys
  if (GAP_CYC < 2) begin : g_bad_gap
    $error("caw_lock: GAP_CYC too small");
  end

  caw_lock_t               st_q;
  caw_lock_t               st_d;
  logic [$clog2(GAP_CYC):0] gap_q;

  // next state of the lock
  // ordered access check
  always_comb begin
    st_d = st_q;
    case (st_q)
      CAW_LK_IDLE: if (key_wr) st_d = (key_data == KEY_FIRST) ? CAW_LK_ONE : CAW_LK_IDLE;
      CAW_LK_ONE:  if (key_wr) st_d = (key_data == KEY_SECOND) ? CAW_LK_TWO : CAW_LK_IDLE;
      CAW_LK_TWO:  if (key_wr) st_d = (key_data == KEY_THIRD) ? CAW_LK_KICK : CAW_LK_IDLE;
      CAW_LK_KICK: st_d = CAW_LK_IDLE;
      default:     st_d = CAW_LK_IDLE;
    endcase
    if ((st_q == CAW_LK_ONE || st_q == CAW_LK_TWO) && !key_wr &&
        gap_q == ($clog2(GAP_CYC)+1)'(GAP_CYC - 1))
      st_d = CAW_LK_IDLE;
  end

  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) st_q <= CAW_LK_IDLE;
    else          st_q <= st_d;
  end

  // gap counter between key writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)                 gap_q <= '0;
    else if (key_wr || st_d == CAW_LK_IDLE) gap_q <= '0;
    else                          gap_q <= gap_q + 1'b1;
  end

  assign kick = (st_q == CAW_LK_KICK);

  chk_kick_needs_third: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    kick |-> $past(key_wr) && $past(key_data) == KEY_THIRD)
    else $error("restart without final key");
  chk_wrong_key_relocks: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (st_q == CAW_LK_ONE && key_wr && key_data != KEY_SECOND) |=> st_q == CAW_LK_IDLE)
    else $error("wrong key did not relock");
endmodule : caw_lock

// ==== testbench/caw_proc_model.sv ====
// Purpose: line-control processor model issuing key writes and the mate activity line
// Assumes: drives just after a rising clock edge
// Notes:   key data shows the inverse of its last value once released
`timescale 1ns/1ps
module caw_proc_model
  import caw_pkg::*;
(
  input  wire logic             core_clk,           // system clock
  output logic                  key_wr,             // key write strobe
  output logic [KEY_W-1:0]      key_data,           // key value
  output logic                  mate_activity_sane  // mate activity line
);
  // idle bus and a sane mate, called by the bench at time zero
  task idle_bus;
    key_wr = 1'b0;
    key_data = '0;
    mate_activity_sane = 1'b1;
  endtask : idle_bus
  // one key per cycle, held until the next edge
  task send_key(input logic [KEY_W-1:0] k);
    @(posedge core_clk);
    #1;
    key_wr = 1'b1;
    key_data = k;
  endtask : send_key
  // release the strobe; stale data is inverted, which turns KEY_SECOND into KEY_FIRST and KEY_FIRST into KEY_SECOND
  task release_bus;
    @(posedge core_clk);
    #1;
    key_wr = 1'b0;
    key_data = ~key_data;
  endtask : release_bus
  task kick_seq;
    send_key(KEY_FIRST);
    send_key(KEY_SECOND);
    send_key(KEY_THIRD);
    release_bus();
  endtask : kick_seq
  // mate line level change
  task set_mate(input logic v);
    @(posedge core_clk);
    #1;
    mate_activity_sane = v;
  endtask : set_mate
endmodule : caw_proc_model

// ==== testbench/controller_activity_watchdog_tb.sv ====
// Purpose: self-checking bench for the activity watchdog
// Assumes: short sanity period of 50 cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module controller_activity_watchdog_tb
  import caw_pkg::*;
;
  localparam int SAN       = 50;   // short sanity period for simulation
  localparam int CYC_LIMIT = 3000; // hang guard ceiling
  logic             core_clk;
  logic             reset_n;
  logic             takeover_cmd;
  logic             return_to_service_cmd;
  logic             failure_ack;
  logic             key_wr;
  logic [KEY_W-1:0] key_data;
  logic             mate_activity_sane;
  logic             activity_sane;
  logic             mate_failed;
  logic             mate_recovered;
  logic             takeover_active;
  logic             primary_bi_en;
  logic             secondary_bi_en;
  logic             ring_if_sel;
  logic             call_drop;
  logic             sel_seen;
  int               err_total = 0;
  int               n_checks = 0;
  int               cyc_q = 0;

  // far side: processor keys and the mate activity line
  caw_proc_model u_proc (
    .core_clk           (core_clk),
    .key_wr             (key_wr),
    .key_data           (key_data),
    .mate_activity_sane (mate_activity_sane)
  );

  // block under test
  caw_watchdog #(
    .SANITY_CYCLES (SAN)
  ) u_dut (
    .core_clk              (core_clk),
    .reset_n               (reset_n),
    .key_wr                (key_wr),
    .key_data              (key_data),
    .mate_activity_sane    (mate_activity_sane),
    .takeover_cmd          (takeover_cmd),
    .return_to_service_cmd (return_to_service_cmd),
    .failure_ack           (failure_ack),
    .activity_sane         (activity_sane),
    .mate_failed           (mate_failed),
    .mate_recovered        (mate_recovered),
    .takeover_active       (takeover_active),
    .primary_bi_en         (primary_bi_en),
    .secondary_bi_en       (secondary_bi_en),
    .ring_if_sel           (ring_if_sel),
    .call_drop             (call_drop)
  );

  // clock
  always #2.5 core_clk = ~core_clk;
  // hang guard
  always @(posedge core_clk) begin
    cyc_q <= cyc_q + 1;
    if (cyc_q == CYC_LIMIT) begin
      err_total++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // one-cycle command pulse: 0 takeover, 1 return, 2 ack
  task pulse(input int w);
    if (w == 0) begin
      takeover_cmd = 1'b1;
    end else if (w == 1) begin
      return_to_service_cmd = 1'b1;
    end else begin
      failure_ack = 1'b1;
    end
    tick(1);
    takeover_cmd = 1'b0;
    return_to_service_cmd = 1'b0;
    failure_ack = 1'b0;
  endtask : pulse
  // timer runs out exactly at the period end, then a full sequence reloads it
  task t_timer;
    tick(40);
    check(activity_sane, 1);
    tick(9);
    check(activity_sane, 1);
    tick(1);
    check(activity_sane, 0);
    u_proc.kick_seq();
    tick(3);
    check(activity_sane, 1);
    tick(47);
    check(activity_sane, 1);
    tick(1);
    check(activity_sane, 0);
  endtask : t_timer
  // wrong key, wrong order and a stale gap never restart; a short gap does
  task t_lock;
    u_proc.send_key(KEY_FIRST);
    u_proc.send_key(KEY_SECOND);
    u_proc.send_key(8'h00);
    u_proc.send_key(KEY_THIRD);
    u_proc.release_bus();
    tick(5);
    check(activity_sane, 0);
    u_proc.send_key(KEY_SECOND);
    u_proc.send_key(KEY_FIRST);
    u_proc.send_key(KEY_THIRD);
    u_proc.release_bus();
    tick(5);
    check(activity_sane, 0);
    u_proc.send_key(KEY_FIRST);
    u_proc.send_key(KEY_SECOND);
    u_proc.release_bus();
    tick(300);
    u_proc.send_key(KEY_THIRD);
    u_proc.release_bus();
    tick(5);
    check(activity_sane, 0);
    u_proc.send_key(KEY_FIRST);
    u_proc.send_key(KEY_SECOND);
    u_proc.release_bus();
    tick(200);
    u_proc.send_key(KEY_THIRD);
    u_proc.release_bus();
    tick(3);
    check(activity_sane, 1);
    u_proc.kick_seq();
    tick(3);
    check(activity_sane, 1);
  endtask : t_lock
  // mate failure flag is sticky until the mate is sane and acknowledged
  task t_mate;
    u_proc.set_mate(1'b0);
    tick(1);
    check(mate_failed, 1);
    pulse(2);
    tick(1);
    check(mate_failed, 1);
    u_proc.set_mate(1'b1);
    pulse(2);
    tick(1);
    check(mate_failed, 0);
  endtask : t_mate
  // takeover, repeated command, sane mate, then manual return
  task t_takeover;
    pulse(0);
    check(takeover_active, 1);
    check(call_drop, 1);
    check({primary_bi_en, secondary_bi_en}, 2'b01);
    sel_seen = ring_if_sel;
    check(sel_seen !== 1'b0 && sel_seen !== 1'b1, 0);
    tick(1);
    check(call_drop, 0);
    pulse(0);
    check(call_drop, 0);
    tick(10);
    check(ring_if_sel, sel_seen);
    check(mate_recovered, 1);
    check(takeover_active, 1);
    pulse(1);
    check(takeover_active, 0);
    check(call_drop, 1);
    check({primary_bi_en, secondary_bi_en}, 2'b10);
    check(mate_recovered, 0);
    tick(1);
    pulse(1);
    check(call_drop, 0);
  endtask : t_takeover
  // reset in mid-run during takeover with a failed mate, then a full period
  task t_reset;
    pulse(0);
    u_proc.set_mate(1'b0);
    tick(1);
    check(mate_failed, 1);
    reset_n = 1'b0;
    tick(2);
    check(takeover_active, 0);
    check(primary_bi_en, 1);
    check(mate_failed, 0);
    check(activity_sane, 1);
    u_proc.set_mate(1'b1);
    reset_n = 1'b1;
    tick(49);
    check(activity_sane, 1);
    tick(1);
    check(activity_sane, 0);
  endtask : t_reset
  // main sequence
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    takeover_cmd = 1'b0;
    return_to_service_cmd = 1'b0;
    failure_ack = 1'b0;
    sel_seen = 1'b0;
    u_proc.idle_bus();
    repeat (6) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    t_timer();
    t_lock();
    t_mate();
    t_takeover();
    t_reset();
    end_sim();
  end
endmodule : controller_activity_watchdog_tb
